//--- src/sird_pkg.sv
// Purpose: constants and types for the status, interrupt and received-data block
// Assumes: 8-bit register address then 16 data bits on the serial port, msb first
// Notes:   offsets, field positions, reset values, bit groups, sizes and types live here
package sird_pkg;
   // ***********************************************************
   // register addresses
   // ***********************************************************
   localparam logic [7:0]  ADDR_AUX_ADC = 8'hb4;
   localparam logic [7:0]  ADDR_RX_WORD = 8'hc5;
   localparam logic [7:0]  ADDR_STATUS  = 8'hc6;
   localparam logic [7:0]  ADDR_PROG    = 8'hc8;
   localparam logic [7:0]  ADDR_TX_DATA = 8'hca;
   localparam logic [7:0]  ADDR_MASK    = 8'hce;
   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int B_IRQ     = 15;
   localparam int B_SELCALL = 13;
   localparam int B_CTCSS   = 11;
   localparam int B_DCS     = 10;
   localparam int B_ADC_HI  = 9;
   localparam int B_ADC_LO  = 8;
   localparam int B_TX_END  = 7;
   localparam int B_XFER    = 6;
   localparam int B_RATE_HI = 4;
   localparam int B_RATE_LO = 3;
   localparam int B_PAT_HI  = 2;
   localparam int B_PAT_LO  = 1;
   localparam int B_PROG    = 0;
   localparam int B_LAST    = 8;
   // ***********************************************************
   // reset values and bit groups
   // ***********************************************************
   localparam logic [15:0] STATUS_RESET  = 16'h0001;
   localparam logic [15:0] MASK_RESET    = 16'h0000;
   localparam logic [15:0] WORD_RESET    = 16'h0000;
   localparam logic [15:0] MASK_USED     = 16'h2fd9;
   localparam logic [15:0] KEEP_ON_READ  = 16'h0001;
   localparam logic [15:0] TONE_BITS     = 16'h2c00;
   localparam logic [15:0] STATUS_RSVD   = 16'h5020;
   localparam logic [4:0]  LAST_ADDR_BIT = 5'h07;
   localparam logic [4:0]  LAST_WORD_BIT = 5'h17;
   localparam logic [5:0]  CTCSS_NONE    = 6'h00;
   localparam logic [5:0]  CTCSS_INVALID = 6'h37;
   localparam int          FIFO_DEPTH    = 8;
   localparam int          RX_WIDTH      = 9;

   typedef struct packed {
      logic       crcOk;
      logic [7:0] data;
   } sird_rxbyte_type;

   typedef struct packed {
      logic [4:0] selcallCode;
      logic [2:0] dcsState;
      logic [5:0] ctcssCode;
   } sird_tone_type;

   typedef struct packed {
      logic        valid;
      logic        above;
      logic        below;
      logic [15:0] result;
   } sird_adc_type;

   typedef struct packed {
      logic       valid;
      logic [1:0] rate;
      logic [1:0] pattern;
   } sird_sync_type;

   typedef enum {SH_IDLE, SH_ADDR, SH_READ, SH_WRITE, SH_SKIP} sird_shift_type;
   typedef enum {TX_RUN, TX_FINISH, TX_HANG} sird_txend_type;
endpackage

//--- src/sird_top.sv
// Purpose: status word, event mask, interrupt pin and received-data word
// Assumes: serial pins are asynchronous; event inputs share clk
// Notes:   received bytes pass an 8-word fifo before the host-visible word
`timescale 1ns/1ns

// ***********************************************************
// fifo
// ***********************************************************
module sird_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,      // system clock
   input  wire logic             rst_b,    // async reset
   input  wire logic [WIDTH-1:0] inData,   // write word
   input  wire logic             inValid,  // write request
   output logic                  inReady,  // room free
   output logic      [WIDTH-1:0] outData,  // head word
   output logic                  outValid, // head present
   input  wire logic             outReady  // drain accepts
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_r;
   logic [AW-1:0]    rdPtr_r;
   logic [AW:0]      count_r;
   logic [AW:0]      count_nxt;
   logic             push;
   logic             pop;

   assign push      = inValid & inReady;
   assign pop       = outValid & outReady;
   assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
   assign outData   = mem[rdPtr_r];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_r] <= inData;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr_r  <= '0;
         rdPtr_r  <= '0;
         count_r  <= '0;
         inReady  <= 1'b0;
         outValid <= 1'b0;
      end else begin
         wrPtr_r  <= wrPtr_r + AW'(push);
         rdPtr_r  <= rdPtr_r + AW'(pop);
         count_r  <= count_nxt;
         inReady  <= count_nxt != (AW+1)'(DEPTH);
         outValid <= count_nxt != '0;
      end
   end
endmodule

module sird_top (
   input  wire logic                     clk,          // 250 MHz clock
   input  wire logic                     rst_b,        // async reset
   input  wire logic                     csN,          // serial select pin
   input  wire logic                     serialClk,    // serial clock pin
   input  wire logic                     cmdIn,        // serial data pin
   output logic                          replyOut,     // serial reply data
   output logic                          replyOe,      // reply drive enable
   output logic                          hostIrqOutN,  // interrupt pin
   input  wire logic                     spPowered,    // processing power bit
   input  wire logic                     txMode,       // transmit selected
   input  wire logic                     rxMode,       // receive selected
   input  wire sird_pkg::sird_tone_type  tone,         // tone decoder state
   input  wire sird_pkg::sird_adc_type   adc,          // aux adc reading
   input  wire sird_pkg::sird_sync_type  frameSync,    // frame sync found
   input  wire logic                     txByteNeeded, // modulator wants byte
   input  wire logic                     modByteDone,  // byte fully sent
   input  wire logic                     modBitDone,   // one bit sent
   input  wire sird_pkg::sird_rxbyte_type rxIn,        // decoded byte
   input  wire logic                     rxInValid,    // decoded byte strobe
   output logic                          rxInReady,    // fifo room
   input  wire logic                     progDone,     // programming finished
   output logic                          progWrite,    // programming word pulse
   output logic                          txDataWrite,  // tx data word pulse
   output logic                   [15:0] wordOut,      // written data word
   output logic                          modStop       // modulator off
);
   // ***********************************************************
   // pin synchronisers
   // ***********************************************************
   logic [1:0] csS_r;
   logic [2:0] sclkS_r;
   logic [1:0] cmdS_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         csS_r   <= 2'h3;
         sclkS_r <= 3'h0;
         cmdS_r  <= 2'h0;
      end else begin
         csS_r   <= {csS_r[0], csN};
         sclkS_r <= {sclkS_r[1:0], serialClk};
         cmdS_r  <= {cmdS_r[0], cmdIn};
      end
   end

   logic sclkRise;
   logic sclkFall;
   logic selected;
   assign selected = ~csS_r[1];
   assign sclkRise = sclkS_r[1] & ~sclkS_r[2];
   assign sclkFall = ~sclkS_r[1] & sclkS_r[2];

   // ***********************************************************
   // serial shifter
   // ***********************************************************
   sird_pkg::sird_shift_type shState_r;
   logic [4:0]  bitCnt_r;
   logic [15:0] inShift_r;
   logic [15:0] outShift_r;
   logic [7:0]  rdAddr_r;
   logic [15:0] status_r;
   logic [15:0] mask_r;
   logic [15:0] auxAdc_r;
   logic [15:0] rxWord_r;

   logic [15:0] shiftedIn;
   logic [7:0]  addrNow;
   logic        addrDone;
   logic        wordDone;
   logic        isRead;
   logic        isWrite;
   logic [15:0] readData;
   logic        statusRead;
   logic        commitProg;
   logic        commitTx;
   logic        commitMask;

   assign shiftedIn = {inShift_r[14:0], cmdS_r[1]};
   assign addrNow   = shiftedIn[7:0];
   assign addrDone  = sclkRise & selected & shState_r == sird_pkg::SH_ADDR & bitCnt_r == sird_pkg::LAST_ADDR_BIT;
   assign wordDone  = sclkRise & selected & shState_r == sird_pkg::SH_WRITE & bitCnt_r == sird_pkg::LAST_WORD_BIT;
   assign isRead    = addrNow == sird_pkg::ADDR_STATUS | addrNow == sird_pkg::ADDR_RX_WORD |
                      addrNow == sird_pkg::ADDR_AUX_ADC;
   assign isWrite   = addrNow == sird_pkg::ADDR_PROG | addrNow == sird_pkg::ADDR_TX_DATA |
                      addrNow == sird_pkg::ADDR_MASK;
   assign readData  = !spPowered ? sird_pkg::WORD_RESET :
                      addrNow == sird_pkg::ADDR_STATUS  ? status_r :
                      addrNow == sird_pkg::ADDR_RX_WORD ? rxWord_r : auxAdc_r;
   assign statusRead = addrDone & addrNow == sird_pkg::ADDR_STATUS;
   assign commitProg = wordDone & rdAddr_r == sird_pkg::ADDR_PROG;
   assign commitTx   = wordDone & rdAddr_r == sird_pkg::ADDR_TX_DATA;
   assign commitMask = wordDone & rdAddr_r == sird_pkg::ADDR_MASK;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shState_r  <= sird_pkg::SH_IDLE;
         bitCnt_r   <= '0;
         inShift_r  <= '0;
         outShift_r <= '0;
         rdAddr_r   <= '0;
      end else if (!selected) begin
         shState_r <= sird_pkg::SH_IDLE;
         bitCnt_r  <= '0;
      end else begin
         case (shState_r)
            sird_pkg::SH_IDLE: begin
               shState_r <= sird_pkg::SH_ADDR;
            end
            sird_pkg::SH_ADDR, sird_pkg::SH_WRITE: begin
               if (sclkRise) begin
                  inShift_r <= shiftedIn;
                  bitCnt_r  <= bitCnt_r + 5'h01;
               end
               if (addrDone) begin
                  rdAddr_r   <= addrNow;
                  outShift_r <= readData;
                  shState_r  <= isRead ? sird_pkg::SH_READ :
                                isWrite ? sird_pkg::SH_WRITE : sird_pkg::SH_SKIP;
               end
               if (wordDone) begin
                  shState_r <= sird_pkg::SH_SKIP;
               end
            end
            sird_pkg::SH_READ: begin
               if (sclkFall) begin
                  outShift_r <= {outShift_r[14:0], 1'b0};
               end
            end
            sird_pkg::SH_SKIP: begin
               shState_r <= sird_pkg::SH_SKIP;
            end
            default: begin
               shState_r <= sird_pkg::SH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         replyOut    <= 1'b0;
         replyOe     <= 1'b0;
         progWrite   <= 1'b0;
         txDataWrite <= 1'b0;
         wordOut     <= '0;
      end else begin
         replyOut    <= outShift_r[15];
         replyOe     <= selected & shState_r == sird_pkg::SH_READ;
         progWrite   <= commitProg;
         txDataWrite <= commitTx;
         if (wordDone) begin
            wordOut <= shiftedIn;
         end
      end
   end

   // ***********************************************************
   // received byte path
   // ***********************************************************
   sird_pkg::sird_rxbyte_type fifoHead;
   logic fifoValid;
   logic drainReady;
   logic rxLoad;

   // word held still while the host shifts it out
   assign drainReady = ~(shState_r == sird_pkg::SH_READ & rdAddr_r == sird_pkg::ADDR_RX_WORD);
   assign rxLoad     = fifoValid & drainReady;

   sird_fifo #(
      .WIDTH(sird_pkg::RX_WIDTH),
      .DEPTH(sird_pkg::FIFO_DEPTH)
   ) rxFifo (
      .clk     (clk),
      .rst_b   (rst_b),
      .inData  (rxIn),
      .inValid (rxInValid),
      .inReady (rxInReady),
      .outData (fifoHead),
      .outValid(fifoValid),
      .outReady(drainReady)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rxWord_r <= sird_pkg::WORD_RESET;
         auxAdc_r <= sird_pkg::WORD_RESET;
      end else begin
         // newest byte overwrites, read or not
         // crc valid lands in bit nine
         if (rxLoad) begin
            rxWord_r <= {6'h00, fifoHead.crcOk, 1'b0, fifoHead.data};
         end
         if (adc.valid) begin
            auxAdc_r <= adc.result;
         end
      end
   end

   // ***********************************************************
   // transmit end sequencing
   // ***********************************************************
   sird_pkg::sird_txend_type txEnd_r;
   logic lastWrite;
   logic txEndPulse;
   assign lastWrite  = commitTx & shiftedIn[sird_pkg::B_LAST];
   assign txEndPulse = txEnd_r == sird_pkg::TX_HANG & modBitDone;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         txEnd_r <= sird_pkg::TX_RUN;
         modStop <= 1'b0;
      end else if (!txMode) begin
         txEnd_r <= sird_pkg::TX_RUN;
         modStop <= 1'b0;
      end else begin
         // current byte, one hang bit, stop
         case (txEnd_r)
            sird_pkg::TX_RUN: begin
               if (lastWrite) begin
                  txEnd_r <= sird_pkg::TX_FINISH;
               end else if (commitTx) begin
                  modStop <= 1'b0;
               end
            end
            sird_pkg::TX_FINISH: begin
               if (modByteDone) begin
                  txEnd_r <= sird_pkg::TX_HANG;
               end
            end
            sird_pkg::TX_HANG: begin
               if (modBitDone) begin
                  txEnd_r <= sird_pkg::TX_RUN;
                  modStop <= 1'b1;
               end
            end
            default: begin
               txEnd_r <= sird_pkg::TX_RUN;
            end
         endcase
      end
   end

   // ***********************************************************
   // event detection
   // ***********************************************************
   sird_pkg::sird_tone_type prevTone_r;
   logic        progFlag_r;
   logic        selcallChg;
   logic        ctcssChg;
   logic        dcsChg;
   logic        progRise;
   logic [15:0] sets;
   logic [15:0] rising;
   logic [15:0] cleared;
   logic [15:0] status_nxt;
   logic        irqSet;

   assign selcallChg = tone.selcallCode != prevTone_r.selcallCode;
   assign ctcssChg   = tone.ctcssCode != prevTone_r.ctcssCode &
                       ~(prevTone_r.ctcssCode == sird_pkg::CTCSS_NONE &
                         tone.ctcssCode == sird_pkg::CTCSS_INVALID);
   // turn-off tone lives in the dcs state
   assign dcsChg     = tone.dcsState != prevTone_r.dcsState;
   assign progRise   = progDone & ~progFlag_r;

   always_comb begin
      sets = 16'h0000;
      sets[sird_pkg::B_SELCALL] = selcallChg & ~txMode;
      sets[sird_pkg::B_CTCSS]   = ctcssChg & ~txMode;
      sets[sird_pkg::B_DCS]     = dcsChg & ~txMode;
      sets[sird_pkg::B_ADC_HI]  = adc.valid & adc.above;
      sets[sird_pkg::B_ADC_LO]  = adc.valid & adc.below;
      sets[sird_pkg::B_TX_END]  = txEndPulse & txMode;
      sets[sird_pkg::B_XFER]    = (txMode & txByteNeeded) | (rxMode & ~txMode & rxLoad);
      sets[sird_pkg::B_RATE_HI] = frameSync.valid & frameSync.rate[1];
      sets[sird_pkg::B_RATE_LO] = frameSync.valid & frameSync.rate[0];
      sets[sird_pkg::B_PAT_HI]  = frameSync.valid & frameSync.pattern[1];
      sets[sird_pkg::B_PAT_LO]  = frameSync.valid & frameSync.pattern[0];
   end

   assign rising  = sets & ~status_r;
   // prog enable fires on rising flag
   assign irqSet  = |(rising & mask_r & sird_pkg::MASK_USED) | (progRise & mask_r[sird_pkg::B_PROG]);
   assign cleared = statusRead ? (status_r & sird_pkg::KEEP_ON_READ) : status_r;

   always_comb begin
      status_nxt = cleared | sets;
      if (frameSync.valid) begin
         status_nxt[sird_pkg::B_RATE_HI:sird_pkg::B_PAT_LO] = {frameSync.rate, frameSync.pattern};
      end
      if (txMode) begin
         status_nxt = status_nxt & ~sird_pkg::TONE_BITS;
      end
      if (!txMode) begin
         status_nxt[sird_pkg::B_TX_END] = 1'b0;
      end
      status_nxt[sird_pkg::B_IRQ]  = cleared[sird_pkg::B_IRQ] | irqSet;
      status_nxt[sird_pkg::B_PROG] = progFlag_r;
      status_nxt = status_nxt & ~sird_pkg::STATUS_RSVD;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prevTone_r  <= '0;
         progFlag_r  <= 1'b1;
         status_r    <= sird_pkg::STATUS_RESET;
         mask_r      <= sird_pkg::MASK_RESET;
         hostIrqOutN <= 1'b1;
      end else begin
         prevTone_r <= tone;
         // completion wins over a same-cycle write
         // early writes still clear the flag
         if (progDone) begin
            progFlag_r <= 1'b1;
         end else if (commitProg) begin
            progFlag_r <= 1'b0;
         end
         status_r <= status_nxt;
         if (commitMask) begin
            mask_r <= shiftedIn;
         end
         hostIrqOutN <= ~(status_nxt[sird_pkg::B_IRQ] & mask_r[sird_pkg::B_IRQ]);
      end
   end
endmodule

//--- sim/sird_props.sv
// Purpose: port-level timing checks for the status and rx-data block
// Assumes: only the top module's ports are visible
// Notes:   attached by the bind at the foot of this file
`timescale 1ns/1ns
// ************************************
// checker
// ************************************
module sird_props (
   input wire logic clk,         // clock
   input wire logic rst_b,       // async reset
   input wire logic csN,         // serial select
   input wire logic replyOe,     // reply enable
   input wire logic replyOut,    // reply data
   input wire logic hostIrqOutN, // interrupt pin
   input wire logic spPowered,   // power bit
   input wire logic txMode,      // transmit mode
   input wire logic modBitDone,  // bit sent
   input wire logic modStop,     // modulator off
   input wire logic progWrite,   // prog pulse
   input wire logic txDataWrite  // tx data pulse
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_quiet; hostIrqOutN [*8]; endsequence
   sequence s_rx2; !txMode [*2]; endsequence
   property p_irq_rst; $rose(rst_b) |-> s_quiet; endproperty
   property p_pwr; replyOe && !spPowered |-> !replyOut; endproperty
   property p_prog; progWrite |=> !progWrite; endproperty
   property p_txw; txDataWrite |=> !txDataWrite; endproperty
   property p_one; !(progWrite && txDataWrite); endproperty
   property p_stop; $rose(modStop) |-> $past(modBitDone) && $past(txMode); endproperty
   property p_stop_rx; s_rx2 |-> !modStop; endproperty
   property p_oe; $rose(replyOe) |-> !csN; endproperty
   a_irq_rst: assert property (p_irq_rst) else $error("irq pin low with mask clear");
   a_pwr: assert property (p_pwr) else $error("reply data while unpowered");
   a_prog: assert property (p_prog) else $error("prog pulse too long");
   a_txw: assert property (p_txw) else $error("tx data pulse too long");
   a_one: assert property (p_one) else $error("two write targets at once");
   a_stop: assert property (p_stop) else $error("modulator stopped without hang bit");
   a_stop_rx: assert property (p_stop_rx) else $error("modulator stop held outside tx");
   a_oe: assert property (p_oe) else $error("reply driven without select");
endmodule

bind sird_top sird_props sird_props_i (.clk, .rst_b, .csN, .replyOe, .replyOut, .hostIrqOutN,
   .spPowered, .txMode, .modBitDone, .modStop, .progWrite, .txDataWrite);

//--- sim/sird_host.sv
// Purpose: host side of the serial register port
// Assumes: 80 ns serial clock, idle low, data taken on rise
// Notes:   a released reply line reads high through its pull-up
`timescale 1ns/1ns
module sird_host (
   input  wire logic clk,       // system clock
   input  wire logic replyOut,  // reply data
   input  wire logic replyOe,   // reply enable
   output logic      csN,       // select
   output logic      serialClk, // serial clock
   output logic      cmdIn      // command data
);
   initial begin
      csN = 1'b1;
      serialClk = 1'b0;
      cmdIn = 1'b0;
   end
   // one frame: 8 address bits, 16 data bits, msb first
   task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
      logic [23:0] w;
      w = {a, d};
      q = 16'h0000;
      @(posedge clk);
      #1 csN = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         cmdIn = w[i];
         repeat (10) @(posedge clk);
         #1 serialClk = 1'b1;
         repeat (10) @(posedge clk);
         #1 if (i <= 16 && i >= 1) q = {q[14:0], replyOe ? replyOut : 1'b1};
         serialClk = 1'b0;
      end
      repeat (10) @(posedge clk);
      #1 csN = 1'b1;
      // stale data must not look valid between frames
      cmdIn = ~cmdIn;
      repeat (10) @(posedge clk);
      // callers drive inputs next, so leave the edge behind
      #1;
   endtask
endmodule

//--- sim/sird_top_tb_top.sv
// Purpose: self-checking bench for the status, mask and rx-data block
// Assumes: host model drives the serial port
// Notes:   event inputs move 1 ns after the clock edge
`timescale 1ns/1ns
module sird_top_tb_top;
   logic                       clk, rst_b, spPowered, txMode, rxMode, full;
   logic                       txByteNeeded, modByteDone, modBitDone, rxInValid, progDone;
   logic                       csN, serialClk, cmdIn, replyOut, replyOe, hostIrqOutN;
   logic                       rxInReady, progWrite, txDataWrite, modStop;
   logic [15:0]                wordOut, q, r;
   logic [8:0]                 last;
   sird_pkg::sird_tone_type    tone;
   sird_pkg::sird_adc_type     adc;
   sird_pkg::sird_sync_type    frameSync;
   sird_pkg::sird_rxbyte_type  rxIn;
   int                         failCount, numChecks, cyc, seed;

   sird_top sird_top_i (.clk, .rst_b, .csN, .serialClk, .cmdIn, .replyOut, .replyOe, .hostIrqOutN,
      .spPowered, .txMode, .rxMode, .tone, .adc, .frameSync, .txByteNeeded, .modByteDone, .modBitDone,
      .rxIn, .rxInValid, .rxInReady, .progDone, .progWrite, .txDataWrite, .wordOut, .modStop);
   sird_host sird_host_i (.clk, .replyOut, .replyOe, .csN, .serialClk, .cmdIn);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ************************************
   // helpers
   // ************************************
   task automatic finalReport;
      $display("checks %0d errors %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      numChecks++;
      if (got !== exp) begin
         failCount++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      sird_host_i.xfer(a, 16'h0000, q);
      chk(q, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      sird_host_i.xfer(a, d, q);
   endtask
   // status with mask enabling the source: summary bit and ready flag added
   function automatic logic [15:0] stw(input logic [15:0] ev);
      return ev | 16'h0001 | ((|ev) ? 16'h8000 : 16'h0000);
   endfunction
   function automatic logic [15:0] rxw(input logic [8:0] x);
      return {6'h00, x[8], 1'b0, x[7:0]};
   endfunction
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         failCount++;
         $display("Error %0t: timeout", $time);
         finalReport();
      end
   end
   // ************************************
   // main sequence
   // ************************************
   initial begin
      seed = 32'h224e;
      rst_b = 1'b0;
      spPowered = 1'b1;
      txMode = 1'b0;
      rxMode = 1'b1;
      {txByteNeeded, modByteDone, modBitDone, rxInValid, progDone} = 5'h00;
      tone = '0;
      adc = '0;
      frameSync = '0;
      rxIn = '0;
      step(12);
      rst_b = 1'b1;
      step(4);
      rd(sird_pkg::ADDR_STATUS, 16'h0001);
      wr(sird_pkg::ADDR_MASK, 16'hffff);
      // mask is write only: the frame writes it and nothing is driven back
      sird_host_i.xfer(sird_pkg::ADDR_MASK, 16'hffff, q);
      chk(q, 16'hffff);
      for (int p = 1; p < 4; p++) begin
         frameSync = {1'b1, 2'(p % 2 + 1), 2'(p)};
         step(1);
         frameSync.valid = 1'b0;
         step(4);
         chk({15'h0000, hostIrqOutN}, 16'h0000);
         rd(sird_pkg::ADDR_STATUS, stw({11'h000, 2'(p % 2 + 1), 2'(p), 1'b0}));
         chk({15'h0000, hostIrqOutN}, 16'h0001);
      end
      // pattern bits alone: their enables are reserved and stay silent
      frameSync = {1'b1, 2'h0, 2'h3};
      step(1);
      frameSync.valid = 1'b0;
      step(4);
      chk({15'h0000, hostIrqOutN}, 16'h0001);
      rd(sird_pkg::ADDR_STATUS, 16'h0007);
      tone.ctcssCode = sird_pkg::CTCSS_INVALID;
      step(4);
      rd(sird_pkg::ADDR_STATUS, 16'h0001);
      tone.dcsState = 3'h5;
      step(4);
      rd(sird_pkg::ADDR_STATUS, stw(16'h0400));
      txMode = 1'b1;
      rxMode = 1'b0;
      tone.selcallCode = 5'($random(seed)) | 5'h01;
      tone.ctcssCode = 6'h01;
      r = 16'($random(seed));
      adc = {3'b111, r};
      step(1);
      adc.valid = 1'b0;
      step(4);
      rd(sird_pkg::ADDR_STATUS, stw(16'h0300));
      rd(sird_pkg::ADDR_AUX_ADC, r);
      txByteNeeded = 1'b1;
      step(1);
      txByteNeeded = 1'b0;
      step(4);
      rd(sird_pkg::ADDR_STATUS, stw(16'h0040));
      wr(sird_pkg::ADDR_TX_DATA, 16'h0100);
      chk(wordOut, 16'h0100);
      modByteDone = 1'b1;
      step(1);
      modByteDone = 1'b0;
      step(3);
      chk({15'h0000, modStop}, 16'h0000);
      modBitDone = 1'b1;
      step(1);
      modBitDone = 1'b0;
      step(3);
      chk({15'h0000, modStop}, 16'h0001);
      rd(sird_pkg::ADDR_STATUS, stw(16'h0080));
      txMode = 1'b0;
      rxMode = 1'b1;
      for (int i = 0; i < 2; i++) begin
         last = 9'($random(seed));
         rxIn = last;
         rxInValid = 1'b1;
         step(1);
         rxInValid = 1'b0;
         modByteDone = 1'b1;
         step(1);
         modByteDone = 1'b0;
         modBitDone = 1'b1;
         step(1);
         modBitDone = 1'b0;
      end
      step(3);
      rd(sird_pkg::ADDR_STATUS, stw(16'h0040));
      rd(sird_pkg::ADDR_RX_WORD, rxw(last));
      // stall the drain with a long word read while the fifo fills
      full = 1'b0;
      fork
         rd(sird_pkg::ADDR_RX_WORD, rxw(last));
         begin
            step(250);
            rxInValid = 1'b1;
            repeat (12) begin
               rxIn = 9'($random(seed));
               if (rxInReady === 1'b1)
                  last = rxIn;
               else
                  full = 1'b1;
               step(1);
            end
            rxInValid = 1'b0;
         end
      join
      step(20);
      chk({15'h0000, full, rxInReady}, 16'h0003);
      rd(sird_pkg::ADDR_RX_WORD, rxw(last));
      rxMode = 1'b0;
      rd(sird_pkg::ADDR_STATUS, stw(16'h0040));
      r = 16'($random(seed));
      wr(sird_pkg::ADDR_PROG, r);
      chk(wordOut, r);
      rd(sird_pkg::ADDR_STATUS, 16'h0000);
      progDone = 1'b1;
      step(1);
      progDone = 1'b0;
      step(4);
      rd(sird_pkg::ADDR_STATUS, 16'h8001);
      for (int i = 1; i >= 0; i--) begin
         wr(sird_pkg::ADDR_MASK, i ? 16'h8000 : 16'h7fff);
         adc.valid = 1'b1;
         step(1);
         adc.valid = 1'b0;
         step(4);
         chk({15'h0000, hostIrqOutN}, 16'h0001);
         rd(sird_pkg::ADDR_STATUS, i ? 16'h0301 : 16'h8301);
      end
      spPowered = 1'b0;
      rd(sird_pkg::ADDR_STATUS, 16'h0000);
      spPowered = 1'b1;
      finalReport();
   end
endmodule
